// ### rds_cfg.svh
// Constants of the random delay switch: widths, reset values, seeds.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef RDS_CFG_SVH
`define RDS_CFG_SVH

// ==========================================================
// Widths
`define RDS_LIM_W 16
`define RDS_RND_W 17

// ==========================================================
// Reset values
`define RDS_ON_LIM_RST 16'h000a
`define RDS_OFF_LIM_RST 16'h000a
`define RDS_CNT_RST 16'h0000
`define RDS_LFSR_SEED 17'h00001

// ==========================================================
// Timing counts, in program ticks
`define RDS_MIN_DELAY 16'h0000
`define RDS_LAST_TICK 16'h0001

// ==========================================================
// Pseudo-random taps, polynomial x^17 + x^14 + 1
`define RDS_TAP_HI 16
`define RDS_TAP_LO 13

`endif

// ### rds_pkg.sv
// Types of the random delay switch.
// Assumes rds_cfg.svh is on the include path.
`include "rds_cfg.svh"

package rds_pkg;

  // ==========================================================
  // Limit sources
  typedef enum logic [1:0] {
    SRC_STORED,
    SRC_VALUE,
    SRC_OUTPUT,
    SRC_COUNT
  } rds_src_t;

  // ==========================================================
  // Stored configuration
  typedef struct packed {
    rds_src_t on_src;
    rds_src_t off_src;
    logic [`RDS_LIM_W-1:0] on_delay_limit;
    logic [`RDS_LIM_W-1:0] off_delay_limit;
  } rds_cfg_t;

  // ==========================================================
  // Live values of other functions
  typedef struct packed {
    logic [`RDS_LIM_W-1:0] analog_value_source;
    logic [`RDS_LIM_W-1:0] analog_output_source;
    logic [`RDS_LIM_W-1:0] counter_value;
  } rds_live_t;

  // ==========================================================
  // Switch states
  typedef enum logic [1:0] {
    ST_LOW,
    ST_ON_WAIT,
    ST_HIGH,
    ST_OFF_WAIT
  } rds_state_t;

endpackage : rds_pkg

// ### rds_lfsr.sv
// Free-running pseudo-random source for the random delay switch.
// Assumes one clock, ref_clk, and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg.svh"

module rds_lfsr
  import rds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  output logic [`RDS_RND_W-1:0] rnd_value
);

  // ==========================================================
  // Shift register
  logic [`RDS_RND_W-1:0] lfsr_q;
  logic [`RDS_RND_W-1:0] lfsr_d;

  always_comb
  begin
    lfsr_d = {lfsr_q[`RDS_RND_W-2:0],
              lfsr_q[`RDS_TAP_HI] ^ lfsr_q[`RDS_TAP_LO]};
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lfsr_q <= `RDS_LFSR_SEED;
    else
      lfsr_q <= lfsr_d;
  end

  assign rnd_value = lfsr_q;

endmodule : rds_lfsr
`default_nettype wire

// ### rds_switch.sv
// Random delay switch: output follows enable after random delays.
// Assumes enable, tick and live values come from logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg.svh"

// Notes on behaviour
// - Rising enable picks random on-delay from zero to on limit, starts it
// - Output goes high when on-delay ends with enable held high
// - Enable falling during on-delay clears timing, output stays low
// - Falling enable picks random off-delay from zero to off limit
// - Output goes low when off-delay ends with enable held low
// - Enable rising during off-delay clears timing, output stays high
// - Each limit comes from stored setting or a live value
module rds_switch
  import rds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic param_mode,
  input wire logic cfg_load,
  input wire rds_cfg_t cfg_in,
  input wire rds_live_t live_in,
  output rds_cfg_t cfg_out,
  output logic switched_out
);

  // ==========================================================
  // Functions
  function automatic logic [`RDS_LIM_W-1:0] scale_delay(
    input logic [`RDS_RND_W-1:0] rnd,
    input logic [`RDS_LIM_W-1:0] lim
  );
    logic [2*`RDS_RND_W-1:0] prod;
    prod = rnd * ({1'b0, lim} + 17'h00001);
    return prod[2*`RDS_RND_W-2:`RDS_RND_W];
  endfunction : scale_delay

  function automatic logic [`RDS_LIM_W-1:0] pick_limit(
    input rds_src_t src,
    input logic [`RDS_LIM_W-1:0] stored,
    input rds_live_t live
  );
    logic [`RDS_LIM_W-1:0] lim;
    lim = stored;
    unique case (src)
      SRC_STORED: lim = stored;
      SRC_VALUE: lim = live.analog_value_source;
      SRC_OUTPUT: lim = live.analog_output_source;
      SRC_COUNT: lim = live.counter_value;
    endcase
    return lim;
  endfunction : pick_limit

  // ==========================================================
  // Random source
  logic [`RDS_RND_W-1:0] rnd_value;

  rds_lfsr rds_lfsr_i (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rnd_value(rnd_value)
  );

  // ==========================================================
  // Configuration store
  rds_cfg_t cfg_q;
  rds_cfg_t cfg_d;

  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_load && param_mode)
      cfg_d = cfg_in;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q.on_src <= SRC_STORED;
      cfg_q.off_src <= SRC_STORED;
      cfg_q.on_delay_limit <= `RDS_ON_LIM_RST;
      cfg_q.off_delay_limit <= `RDS_OFF_LIM_RST;
    end
    else
      cfg_q <= cfg_d;
  end

  assign cfg_out = cfg_q;

  // ==========================================================
  // Delay timing
  logic [`RDS_LIM_W-1:0] on_lim;
  logic [`RDS_LIM_W-1:0] off_lim;
  logic [`RDS_LIM_W-1:0] on_draw;
  logic [`RDS_LIM_W-1:0] off_draw;
  rds_state_t state_q;
  rds_state_t state_d;
  logic [`RDS_LIM_W-1:0] cnt_q;
  logic [`RDS_LIM_W-1:0] cnt_d;
  logic out_q;
  logic out_d;

  always_comb
  begin
    on_lim = pick_limit(cfg_q.on_src, cfg_q.on_delay_limit, live_in);
    off_lim = pick_limit(cfg_q.off_src, cfg_q.off_delay_limit,
                         live_in);
    on_draw = scale_delay(rnd_value, on_lim);
    off_draw = scale_delay(rnd_value, off_lim);
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    out_d = out_q;
    unique case (state_q)
      ST_LOW:
      begin
        if (enable)
        begin
          if (on_draw == `RDS_MIN_DELAY)
          begin
            state_d = ST_HIGH;
            out_d = 1'b1;
          end
          else
          begin
            state_d = ST_ON_WAIT;
            cnt_d = on_draw;
          end
        end
      end
      ST_ON_WAIT:
      begin
        if (!enable)
        begin
          state_d = ST_LOW;
          cnt_d = `RDS_CNT_RST;
        end
        else if (tick)
        begin
          if (cnt_q == `RDS_LAST_TICK)
          begin
            state_d = ST_HIGH;
            cnt_d = `RDS_CNT_RST;
            out_d = 1'b1;
          end
          else
            cnt_d = cnt_q - `RDS_LAST_TICK;
        end
      end
      ST_HIGH:
      begin
        if (!enable)
        begin
          if (off_draw == `RDS_MIN_DELAY)
          begin
            state_d = ST_LOW;
            out_d = 1'b0;
          end
          else
          begin
            state_d = ST_OFF_WAIT;
            cnt_d = off_draw;
          end
        end
      end
      ST_OFF_WAIT:
      begin
        if (enable)
        begin
          state_d = ST_HIGH;
          cnt_d = `RDS_CNT_RST;
        end
        else if (tick)
        begin
          if (cnt_q == `RDS_LAST_TICK)
          begin
            state_d = ST_LOW;
            cnt_d = `RDS_CNT_RST;
            out_d = 1'b0;
          end
          else
            cnt_d = cnt_q - `RDS_LAST_TICK;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_LOW;
      cnt_q <= `RDS_CNT_RST;
      out_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign switched_out = out_q;

  // ==========================================================
  // Assertions
  sequence on_edge_s;
    state_q == ST_LOW && enable;
  endsequence

  sequence off_edge_s;
    state_q == ST_HIGH && !enable;
  endsequence

  sequence on_last_s;
    state_q == ST_ON_WAIT && enable && tick && cnt_q == `RDS_LAST_TICK;
  endsequence

  sequence off_last_s;
    state_q == ST_OFF_WAIT && !enable && tick && cnt_q == `RDS_LAST_TICK;
  endsequence

  on_start_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    on_edge_s |=> (state_q == ST_ON_WAIT && cnt_q != `RDS_MIN_DELAY)
      || (state_q == ST_HIGH && switched_out))
    else $error("on-delay not started on rising enable");

  on_expire_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    on_last_s |=> switched_out && state_q == ST_HIGH)
    else $error("output not set at end of on-delay");

  rise_cause_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(switched_out) |-> $past(enable))
    else $error("output rose without enable held");

  on_abort_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state_q == ST_ON_WAIT && !enable |=>
      state_q == ST_LOW && cnt_q == `RDS_CNT_RST && !switched_out)
    else $error("on-delay not cleared on falling enable");

  off_start_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    off_edge_s |=> (state_q == ST_OFF_WAIT && switched_out)
      || (state_q == ST_LOW && !switched_out))
    else $error("off-delay not started on falling enable");

  off_expire_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    off_last_s |=> !switched_out && state_q == ST_LOW)
    else $error("output not cleared at end of off-delay");

  off_abort_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state_q == ST_OFF_WAIT && enable |=>
      state_q == ST_HIGH && cnt_q == `RDS_CNT_RST && switched_out)
    else $error("off-delay not cleared on rising enable");

  live_limit_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    on_edge_s ##0 cfg_q.on_src == SRC_VALUE |=>
      cnt_q <= $past(live_in.analog_value_source))
    else $error("on-delay exceeds live limit");

  cfg_guard_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !(cfg_load && param_mode) |=> $stable(cfg_q))
    else $error("configuration changed outside adjustment mode");

  draw_range_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    off_edge_s |=> cnt_q <= $past(off_lim))
    else $error("off-delay drawn above its limit");

  cnt_step_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    state_q == ST_ON_WAIT && enable && tick && cnt_q > `RDS_LAST_TICK |=>
      cnt_q == $past(cnt_q) - `RDS_LAST_TICK)
    else $error("on-delay count did not step by one");

endmodule : rds_switch
`default_nettype wire

// ### rds_far_model.sv
// Far-side model: the logic that feeds enable, tick and the limit setup.
// Assumes its tasks are called at a falling edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg.svh"

module rds_far_model
  import rds_pkg::*;
(
  input wire logic ref_clk,
  output logic enable,
  output logic tick,
  output logic param_mode,
  output logic cfg_load,
  output rds_cfg_t cfg_in,
  output rds_live_t live_in
);
  // ==========================================================
  // Idle levels
  initial
  begin
    enable = 1'b0;
    tick = 1'b0;
    param_mode = 1'b0;
    cfg_load = 1'b0;
    cfg_in = '0;
    live_in = {16'h0003, 16'h0005, 16'h0007};
  end

  // ==========================================================
  // Requests
  task automatic drive(input logic en);
    enable = en;
  endtask : drive

  task automatic set_tick(input logic on);
    tick = on;
  endtask : set_tick

  // Live values of the other functions that may supply a limit
  task automatic set_live(input logic [15:0] v, input logic [15:0] o,
                          input logic [15:0] n);
    live_in = {v, o, n};
  endtask : set_live

  // Limits change only with the adjustment mode raised
  task automatic load(input logic mode, input rds_cfg_t c);
    param_mode = mode;
    cfg_in = c;
    cfg_load = 1'b1;
    @(negedge ref_clk);
    cfg_load = 1'b0;
    @(negedge ref_clk);
  endtask : load
endmodule : rds_far_model
`default_nettype wire

// ### rds_switch_tb.sv
// Self-checking bench for the random delay switch.
// Assumes rds_pkg, rds_switch and rds_far_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "rds_cfg.svh"

module rds_switch_tb
  import rds_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic enable, tick, param_mode, cfg_load, switched_out;
  rds_cfg_t cfg_in, cfg_out;
  rds_live_t live_in;
  logic [`RDS_RND_W-1:0] m_lfsr;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  rds_switch rds_switch_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .enable(enable), .tick(tick), .param_mode(param_mode),
    .cfg_load(cfg_load), .cfg_in(cfg_in), .live_in(live_in),
    .cfg_out(cfg_out), .switched_out(switched_out));
  rds_far_model rds_far_model_i (.ref_clk(ref_clk), .enable(enable),
    .tick(tick), .param_mode(param_mode), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .live_in(live_in));

  // ==========================================================
  // Clock, random source model, timeout
  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      m_lfsr <= `RDS_LFSR_SEED;
    else
      m_lfsr <= {m_lfsr[15:0], m_lfsr[`RDS_TAP_HI] ^ m_lfsr[`RDS_TAP_LO]};

  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] draw(input logic [15:0] lim);
    logic [33:0] p;
    p = {17'h00000, m_lfsr} * {17'h00000, {1'b0, lim} + 17'h00001};
    return p[32:17];
  endfunction : draw

  function automatic logic [15:0] pick(input rds_src_t s,
                                       input logic [15:0] st);
    case (s)
      SRC_VALUE: return live_in.analog_value_source;
      SRC_OUTPUT: return live_in.analog_output_source;
      SRC_COUNT: return live_in.counter_value;
      default: return st;
    endcase
  endfunction : pick

  task automatic check_out(input logic exp);
    compares++;
    if (switched_out !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: switched_out %b", $time, switched_out);
    end
  endtask : check_out

  task automatic check_cfg(input rds_cfg_t exp);
    compares++;
    if (cfg_out !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: cfg_out %h", $time, cfg_out);
    end
  endtask : check_cfg

  // One edge of enable, ticks every cycle, exact expiry checked
  task automatic step(input logic en, input logic [15:0] lim);
    logic [15:0] d;
    d = draw(lim);
    rds_far_model_i.drive(en);
    repeat (d) @(negedge ref_clk);
    check_out(!en);
    @(negedge ref_clk);
    check_out(en);
  endtask : step

  // ==========================================================
  // Scenarios
  task automatic reset_and_config();
    rds_cfg_t c;
    c = {SRC_COUNT, SRC_VALUE, 16'h1234, 16'h00ab};
    check_out(1'b0);
    check_cfg({SRC_STORED, SRC_STORED, 16'h000a, 16'h000a});
    rds_far_model_i.load(1'b0, c);
    check_cfg({SRC_STORED, SRC_STORED, 16'h000a, 16'h000a});
    rds_far_model_i.load(1'b1, c);
    check_cfg(c);
  endtask : reset_and_config

  task automatic limit_sources();
    rds_src_t s;
    rds_cfg_t c;
    rds_far_model_i.set_tick(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      s = rds_src_t'(i);
      rds_far_model_i.set_live(16'(i + 2), 16'(i + 5), 16'(i + 8));
      c = {s, s, 16'h0004, 16'h0006};
      rds_far_model_i.load(1'b1, c);
      check_cfg(c);
      repeat (4)
      begin
        step(1'b1, pick(s, 16'h0004));
        step(1'b0, pick(s, 16'h0006));
      end
    end
    rds_far_model_i.load(1'b1, {SRC_STORED, SRC_STORED, 16'h0000, 16'h0000});
    step(1'b1, 16'h0000);
    step(1'b0, 16'h0000);
  endtask : limit_sources

  task automatic abort_delays();
    logic [15:0] d;
    rds_far_model_i.set_tick(1'b0);
    rds_far_model_i.load(1'b1, {SRC_STORED, SRC_STORED, 16'hffff, 16'hffff});
    d = draw(16'hffff);
    rds_far_model_i.drive(1'b1);
    repeat (3) @(negedge ref_clk);
    rds_far_model_i.drive(1'b0);
    repeat (3) @(negedge ref_clk);
    check_out(d == 16'h0000);
    rds_far_model_i.set_tick(1'b1);
    rds_far_model_i.load(1'b1, {SRC_STORED, SRC_STORED, 16'h0003, 16'h0003});
    step(1'b1, 16'h0003);
    rds_far_model_i.set_tick(1'b0);
    rds_far_model_i.load(1'b1, {SRC_STORED, SRC_STORED, 16'hffff, 16'hffff});
    d = draw(16'hffff);
    rds_far_model_i.drive(1'b0);
    repeat (3) @(negedge ref_clk);
    rds_far_model_i.drive(1'b1);
    repeat (3) @(negedge ref_clk);
    check_out(d != 16'h0000);
    rds_far_model_i.set_tick(1'b1);
    rds_far_model_i.load(1'b1, {SRC_STORED, SRC_STORED, 16'h0003, 16'h0003});
    if (d != 16'h0000)
      step(1'b0, 16'h0003);
  endtask : abort_delays

  // ==========================================================
  // Verdict and main sequence
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    reset_and_config();
    limit_sources();
    abort_delays();
    wrap_up();
  end
endmodule : rds_switch_tb
`default_nettype wire
